//--- hdl/csc_pkg.sv
/*
  Constants shared by the channel state control block: register indices,
  field positions, widths and reset values.
  Assumes a 32-bit Avalon-MM slave with byte addresses of four times the index.
*/
package csc_pkg;

  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDX_W  = 16;
  localparam int BE_W   = 4;

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_STATUS   = 16'hE8A8;
  localparam logic [IDX_W-1:0] IDX_MODIFY   = 16'hE8AA;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 16'hE8F0;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 16'hE8F2;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 16'hE8F4;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int N_CH     = 4;
  localparam int N_CAP    = 3;
  localparam int N_OUT    = 7;
  localparam int N_T1_OUT = 6;
  localparam int HALL_W   = 3;
  localparam int HALL_LSB = 3;
  localparam int PS_LSB   = 8;
  localparam int IM_BIT   = 15;
  localparam int FLAG_BIT [N_CH] = '{0, 1, 2, 6};
  localparam int CLR_BIT  [N_CH] = '{8, 9, 10, 14};

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [REG_W-1:0]  STATUS_RST = 16'h0000;
  localparam logic [N_OUT-1:0]  PS_RST     = 7'h00;
  localparam logic [N_CH-1:0]   FLAG_RST   = 4'h0;
  localparam logic [N_CH-1:0]   IRQ_RST    = 4'h0;
  localparam logic [HALL_W-1:0] HALL_RST   = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST  = 32'h0000_0000;

endpackage

//--- hdl/csc_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; the value changes once stages two and three
  agree.
*/
`timescale 1ns/1ps

module csc_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  if (WIDTH < 1) begin : g_chk
    $error("csc_sync: WIDTH must be at least 1");
  end

  // ----------------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per-bit agreement of stages two and three
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        stable_out[i] <= 1'b0;
      end else if (s2_r[i] == s3_r[i]) begin
        stable_out[i] <= s3_r[i];
      end
    end
  end

endmodule // csc_sync

//--- hdl/csc_out_stage.sv
/*
  Output level stage for the seven compare outputs.
  Assumes flags, select bits and levels come from the state control core on
  the same clock; outputs are registered.
*/
`timescale 1ns/1ps

module csc_out_stage #(
  parameter int N = 7
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [N-1:0] flag_in,
  input  wire logic [N-1:0] passive_sel_in,
  input  wire logic [N-1:0] capture_in,
  input  wire logic [N-1:0] passive_level_in,
  input  wire logic [N-1:0] mod_en_in,
  input  wire logic         cmp_sig_in,
  input  wire logic         invert_in,
  output logic      [N-1:0] pin_out
);

  logic mod_sig;

  if (N < 1) begin : g_chk
    $error("csc_out_stage: N must be at least 1");
  end

  // passive when flag equals the select bit; select ignored in capture
  function automatic logic is_passive(input logic flag, input logic sel,
                                      input logic cap);
    is_passive = !cap && (flag == sel);
  endfunction

  assign mod_sig = cmp_sig_in ^ invert_in;

  // ----------------------------------------------------------------------
  // per output level
  // ----------------------------------------------------------------------
  for (genvar j = 0; j < N; j++) begin : g_out
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        pin_out[j] <= 1'b0;
      end else if (is_passive(flag_in[j], passive_sel_in[j],
                              capture_in[j]) ||
                   (mod_en_in[j] && !mod_sig)) begin
        pin_out[j] <= passive_level_in[j];
      end else begin
        pin_out[j] <= ~passive_level_in[j];
      end
    end
  end

endmodule // csc_out_stage

//--- hdl/csc_core.sv
/*
  Channel state control for a seven-output capture/compare unit: state flags,
  shadowed passive-state selects, inverted modulation control, Hall sample
  bits, set/clear/toggle register and an event interrupt.
  Assumes timer switching events, shadow-transfer strobes and capture-mode
  selects arrive as same-clock pulses or levels from the timer logic; the
  Hall pins are asynchronous.
*/
`timescale 1ns/1ps

module csc_core
  import csc_pkg::*;
(
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic [csc_pkg::ADDR_W-1:0]  avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [csc_pkg::DATA_W-1:0]  avs_writedata_in,
  input  wire logic [csc_pkg::BE_W-1:0]    avs_byteenable_in,
  output logic      [csc_pkg::DATA_W-1:0]  avs_readdata_out,
  output logic                             avs_waitrequest_out,
  input  wire logic [csc_pkg::N_CH-1:0]    hw_set_in,
  input  wire logic [csc_pkg::N_CH-1:0]    hw_clr_in,
  input  wire logic [csc_pkg::N_CAP-1:0]   capture_mode_in,
  input  wire logic                        first_timer_shadow_in,
  input  wire logic                        second_timer_shadow_in,
  input  wire logic [csc_pkg::HALL_W-1:0]  hall_pin_in,
  input  wire logic                        hall_sample_in,
  input  wire logic                        second_timer_compare_signal_in,
  input  wire logic [csc_pkg::N_OUT-1:0]   passive_level_register_in,
  input  wire logic [csc_pkg::N_T1_OUT-1:0] second_timer_mod_en_in,
  output logic      [csc_pkg::N_CAP-1:0]   channel_output_out,
  output logic      [csc_pkg::N_CAP-1:0]   complement_output_out,
  output logic                             second_timer_output_out,
  output logic      [csc_pkg::N_CH-1:0]    channel_state_flag_out,
  output logic                             irq_out
);
  import csc_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic                ack_r;
  logic [DATA_W-1:0]   rdata_r;
  logic [DATA_W-1:0]   rdata_nxt;
  logic                req;
  logic                wr_acc;
  logic [REG_W-1:0]    wmask;
  logic [REG_W-1:0]    wdata;
  logic                stat_wr;
  logic                mod_wr;
  logic                iclr_wr;
  logic                ien_wr;
  logic                im_r;
  logic [N_OUT-1:0]    ps_sh_r;
  logic [N_OUT-1:0]    ps_r;
  logic [N_CH-1:0]     flag_r;
  logic [N_CH-1:0]     sw_set;
  logic [N_CH-1:0]     sw_clr;
  logic [N_CH-1:0]     cap_ch;
  logic [N_CH-1:0]     hw_event;
  logic [N_CH-1:0]     irq_stat_r;
  logic [N_CH-1:0]     irq_en_r;
  logic                irq_r;
  logic [HALL_W-1:0]   hall_sync;
  logic [HALL_W-1:0]   hall_r;
  logic [REG_W-1:0]    status_view;
  logic [N_OUT-1:0]    out_flag;
  logic [N_OUT-1:0]    out_cap;
  logic [N_OUT-1:0]    out_mod_en;
  logic [N_OUT-1:0]    out_pins;

  // byte address of a register index
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [IDX_W-1:0]  idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------------
  // avalon slave: one wait state for every access
  // ----------------------------------------------------------------------
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_r;
  assign wr_acc              = avs_write_in & ack_r;
  assign wmask   = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wdata   = avs_writedata_in[REG_W-1:0] & wmask;
  assign stat_wr = wr_acc & hit(avs_address_in, IDX_STATUS);
  assign mod_wr  = wr_acc & hit(avs_address_in, IDX_MODIFY);
  assign iclr_wr = wr_acc & hit(avs_address_in, IDX_IRQ_CLR);
  assign ien_wr  = wr_acc & hit(avs_address_in, IDX_IRQ_EN);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // status view: active selects, flags and sampled Hall bits
  always_comb begin
    status_view = STATUS_RST;
    status_view[IM_BIT] = im_r;
    status_view[PS_LSB +: N_OUT] = ps_r;
    status_view[HALL_LSB +: HALL_W] = hall_r;
    for (int k = 0; k < N_CH; k++) begin
      status_view[FLAG_BIT[k]] = flag_r[k];
    end
  end

  // modify and clear registers read as zero, unmapped addresses too
  always_comb begin
    rdata_nxt = RDATA_RST;
    if (hit(avs_address_in, IDX_STATUS)) begin
      rdata_nxt[REG_W-1:0] = status_view;
    end else if (hit(avs_address_in, IDX_IRQ_STAT)) begin
      rdata_nxt[N_CH-1:0] = irq_stat_r;
    end else if (hit(avs_address_in, IDX_IRQ_EN)) begin
      rdata_nxt[N_CH-1:0] = irq_en_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= RDATA_RST;
    end else if (avs_read_in && !ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;

  // ----------------------------------------------------------------------
  // inverted modulation control and passive-state selects
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      im_r <= 1'b0;
    end else if (stat_wr && wmask[IM_BIT]) begin
      im_r <= wdata[IM_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ps_sh_r <= PS_RST;
    end else if (stat_wr) begin
      ps_sh_r <= (ps_sh_r & ~wmask[PS_LSB +: N_OUT]) |
                 wdata[PS_LSB +: N_OUT];
    end
  end

  // first timer moves the six channel selects, second timer its own
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ps_r <= PS_RST;
    end else begin
      if (first_timer_shadow_in) begin
        ps_r[N_T1_OUT-1:0] <= ps_sh_r[N_T1_OUT-1:0];
      end
      if (second_timer_shadow_in) begin
        ps_r[N_OUT-1] <= ps_sh_r[N_OUT-1];
      end
    end
  end

  // ----------------------------------------------------------------------
  // channel state flags
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < N_CH; i++) begin : g_flag
    if (i < N_CAP) begin : g_cap
      assign cap_ch[i] = capture_mode_in[i];
    end else begin : g_cmp
      assign cap_ch[i] = 1'b0;
    end

    assign sw_set[i] = mod_wr & wdata[FLAG_BIT[i]];
    assign sw_clr[i] = mod_wr & wdata[CLR_BIT[i]];
    assign hw_event[i] = hw_set_in[i] & ~flag_r[i] &
                         ~(sw_set[i] | sw_clr[i]);

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        flag_r[i] <= 1'b0;
      end else if (sw_set[i] && sw_clr[i]) begin
        flag_r[i] <= ~flag_r[i];
      end else if (sw_set[i]) begin
        flag_r[i] <= 1'b1;
      end else if (sw_clr[i]) begin
        flag_r[i] <= 1'b0;
      end else if (hw_set_in[i]) begin
        flag_r[i] <= 1'b1;
      end else if (hw_clr_in[i] && !cap_ch[i]) begin
        flag_r[i] <= 1'b0;
      end
    end
  end

  assign channel_state_flag_out = flag_r;

  // ----------------------------------------------------------------------
  // hall sample bits
  // ----------------------------------------------------------------------
  csc_sync #(
    .WIDTH (HALL_W)
  ) u_hall_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   (hall_pin_in),
    .stable_out (hall_sync)
  );

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hall_r <= HALL_RST;
    end else if (hall_sample_in) begin
      hall_r <= hall_sync;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt: sticky status, write-one clear, enable
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= IRQ_RST;
    end else begin
      irq_stat_r <= (irq_stat_r &
                     ~(iclr_wr ? wdata[N_CH-1:0] : IRQ_RST)) | hw_event;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_en_r <= IRQ_RST;
    end else if (ien_wr) begin
      irq_en_r <= (irq_en_r & ~wmask[N_CH-1:0]) | wdata[N_CH-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  assign irq_out = irq_r;

  // ----------------------------------------------------------------------
  // output stage: outputs ordered as the select bits
  // ----------------------------------------------------------------------
  for (genvar j = 0; j < N_T1_OUT; j++) begin : g_map
    assign out_flag[j]   = flag_r[j/2];
    assign out_cap[j]    = capture_mode_in[j/2];
    assign out_mod_en[j] = second_timer_mod_en_in[j];
  end
  assign out_flag[N_OUT-1]   = flag_r[N_CH-1];
  assign out_cap[N_OUT-1]    = 1'b0;
  assign out_mod_en[N_OUT-1] = 1'b0;

  csc_out_stage #(
    .N (N_OUT)
  ) u_out (
    .ref_clk_in       (ref_clk_in),
    .rst_n_in         (rst_n_in),
    .flag_in          (out_flag),
    .passive_sel_in   (ps_r),
    .capture_in       (out_cap),
    .passive_level_in (passive_level_register_in),
    .mod_en_in        (out_mod_en),
    .cmp_sig_in       (second_timer_compare_signal_in),
    .invert_in        (im_r),
    .pin_out          (out_pins)
  );

  for (genvar c = 0; c < N_CAP; c++) begin : g_pins
    assign channel_output_out[c]    = out_pins[2*c];
    assign complement_output_out[c] = out_pins[2*c+1];
  end
  assign second_timer_output_out = out_pins[N_OUT-1];

endmodule // csc_core

//--- test/csc_core_properties.sv
/*
  Checker for the channel state control core: flags, selects, read data
  and output levels. Assumes a master that holds each request until
  waitrequest is low and always drives all byte lanes.
*/
`timescale 1ns/1ps

module csc_core_chk
  import csc_pkg::*;
(
  input wire logic                         ref_clk_in,
  input wire logic                         rst_n_in,
  input wire logic [csc_pkg::ADDR_W-1:0]   avs_address_in,
  input wire logic                         avs_read_in,
  input wire logic                         avs_write_in,
  input wire logic [csc_pkg::DATA_W-1:0]   avs_writedata_in,
  input wire logic [csc_pkg::DATA_W-1:0]   avs_readdata_out,
  input wire logic                         avs_waitrequest_out,
  input wire logic [csc_pkg::N_CH-1:0]     hw_set_in,
  input wire logic [csc_pkg::N_CH-1:0]     hw_clr_in,
  input wire logic [csc_pkg::N_CAP-1:0]    capture_mode_in,
  input wire logic                         first_timer_shadow_in,
  input wire logic                         second_timer_shadow_in,
  input wire logic                         second_timer_compare_signal_in,
  input wire logic [csc_pkg::N_OUT-1:0]    passive_level_register_in,
  input wire logic [csc_pkg::N_T1_OUT-1:0] second_timer_mod_en_in,
  input wire logic [csc_pkg::N_CAP-1:0]    channel_output_out,
  input wire logic [csc_pkg::N_CAP-1:0]    complement_output_out,
  input wire logic                         second_timer_output_out,
  input wire logic [csc_pkg::N_CH-1:0]     channel_state_flag_out
);
  // --------------------------------------------------------------
  // shadow model of inversion and select bits
  // --------------------------------------------------------------
  logic [N_OUT-1:0] sh_r, act_r, exp_pin, pins;
  logic [N_CH-1:0]  sw_nxt;
  logic [REG_W-1:0] stat_exp;
  logic             inv_r, mod_wr, stat_rd, mod_rd;
  wire  [DATA_W-1:0] wd = avs_writedata_in;
  wire  [N_CH-1:0]   fl = channel_state_flag_out;

  assign mod_wr  = avs_write_in && !avs_waitrequest_out &&
                   avs_address_in == {IDX_MODIFY, 2'b00};
  assign stat_rd = avs_read_in && !avs_waitrequest_out &&
                   avs_address_in == {IDX_STATUS, 2'b00};
  assign mod_rd  = avs_read_in && !avs_waitrequest_out &&
                   avs_address_in == {IDX_MODIFY, 2'b00};
  assign pins = {second_timer_output_out,
                 complement_output_out[2], channel_output_out[2],
                 complement_output_out[1], channel_output_out[1],
                 complement_output_out[0], channel_output_out[0]};
  assign stat_exp = {inv_r, act_r, 1'b0, fl[3], 3'h0, fl[2:0]};

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_r  <= PS_RST;
      act_r <= PS_RST;
      inv_r <= 1'b0;
    end else begin
      if (avs_write_in && !avs_waitrequest_out &&
          avs_address_in == {IDX_STATUS, 2'b00}) begin
        sh_r  <= wd[14:8];
        inv_r <= wd[IM_BIT];
      end
      if (first_timer_shadow_in) act_r[5:0] <= sh_r[5:0];
      if (second_timer_shadow_in) act_r[6] <= sh_r[6];
    end
  end

  always_comb begin
    for (int k = 0; k < N_CH; k++) begin
      sw_nxt[k] = (wd[FLAG_BIT[k]] && wd[CLR_BIT[k]]) ? !fl[k] :
                  (wd[FLAG_BIT[k]] || (fl[k] && !wd[CLR_BIT[k]]));
    end
    for (int j = 0; j < N_OUT; j++) begin
      exp_pin[j] = ((!(j < 6 && capture_mode_in[j/2]) &&
                     fl[j/2] == act_r[j]) ||
                    (j < 6 && second_timer_mod_en_in[j] &&
                     !(second_timer_compare_signal_in ^ inv_r))) ?
                   passive_level_register_in[j] :
                   !passive_level_register_in[j];
    end
  end

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_mod_wr;
    mod_wr;
  endsequence
  sequence s_stat_rd;
    stat_rd;
  endsequence

  a_sw_modify_flags: assert property (
    s_mod_wr |=> fl == $past(sw_nxt)) else $error("flag modify wrong");
  a_hw_set_flag: assert property (
    hw_set_in[3] && !mod_wr |=> fl[3]) else $error("hw set lost");
  a_hw_clr_flag: assert property (
    hw_clr_in[3] && !hw_set_in[3] && !mod_wr |=> !fl[3])
    else $error("hw clear lost");
  a_capture_flag_hold: assert property (
    capture_mode_in[0] && fl[0] && !mod_wr |=> fl[0])
    else $error("capture flag dropped");
  a_flags_hold: assert property (
    hw_set_in == 4'h0 && hw_clr_in == 4'h0 && !mod_wr |=> $stable(fl))
    else $error("flag moved without cause");
  a_out_level: assert property (
    1'b1 |=> pins == $past(exp_pin)) else $error("output level wrong");
  a_status_read: assert property (
    s_stat_rd |-> (avs_readdata_out & 32'h0000_FFC7) ==
                  {16'h0000, $past(stat_exp)})
    else $error("status read wrong");
  a_one_wait_state: assert property (
    $rose(avs_read_in || avs_write_in) |->
      avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("wait state count wrong");
  a_modify_reads_zero: assert property (
    mod_rd |-> avs_readdata_out == RDATA_RST)
    else $error("modify read not zero");
  a_reset_zero: assert property (disable iff (1'b0)
    !rst_n_in |-> fl == FLAG_RST && avs_readdata_out == RDATA_RST)
    else $error("reset value wrong");
endmodule // csc_core_chk

bind csc_core csc_core_chk u_chk (.*);

//--- test/test_compare_channel_state_control.sv
/*
  Self-checking bench for the channel state control core.
  Assumes the core answers Avalon-MM requests with waitrequest.
*/
`timescale 1ns/1ps

module test_compare_channel_state_control
  import csc_pkg::*;
;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic ref_clk_in, rst_n_in, avs_read_in, avs_write_in;
  logic avs_waitrequest_out, first_timer_shadow_in, second_timer_shadow_in;
  logic hall_sample_in, second_timer_compare_signal_in;
  logic second_timer_output_out, irq_out, m_inv;
  logic [ADDR_W-1:0]   avs_address_in;
  logic [DATA_W-1:0]   avs_writedata_in, avs_readdata_out, rd;
  logic [BE_W-1:0]     avs_byteenable_in;
  logic [N_CH-1:0]     hw_set_in, hw_clr_in, channel_state_flag_out;
  logic [N_CH-1:0]     m_flag, m_prev, m_irq, s, c;
  logic [N_CAP-1:0]    capture_mode_in, channel_output_out;
  logic [N_CAP-1:0]    complement_output_out;
  logic [HALL_W-1:0]   hall_pin_in;
  logic [N_OUT-1:0]    passive_level_register_in, m_sh, m_act, pins;
  logic [N_T1_OUT-1:0] second_timer_mod_en_in;
  logic [15:0]         wd;
  int                  err_total, samples_checked, seed;

  assign pins = {second_timer_output_out,
                 complement_output_out[2], channel_output_out[2],
                 complement_output_out[1], channel_output_out[1],
                 complement_output_out[0], channel_output_out[0]};

  csc_core uut (.*);

  always #20 ref_clk_in = !ref_clk_in;

  // --------------------------------------------------------------
  // tasks and expectations
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [15:0] idx, d);
    @(posedge ref_clk_in);
    avs_address_in   <= {idx, 2'b00};
    avs_writedata_in <= {16'h0000, d};
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge ref_clk_in);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] stat_exp(input logic [2:0] h);
    return {16'h0000, m_inv, m_act, 1'b0, m_flag[3], h, m_flag[2:0]};
  endfunction

  function automatic logic [3:0] sw_mod(input logic [3:0] f,
                                        input logic [15:0] d);
    logic [3:0] n;
    for (int k = 0; k < N_CH; k++) begin
      case ({d[FLAG_BIT[k]], d[CLR_BIT[k]]})
        2'b11: n[k] = !f[k];
        2'b10: n[k] = 1'b1;
        2'b01: n[k] = 1'b0;
        default: n[k] = f[k];
      endcase
    end
    return n;
  endfunction

  function automatic logic [6:0] out_exp(input logic [3:0] f);
    logic [6:0] o;
    logic       pas, md;
    for (int j = 0; j < 7; j++) begin
      pas = !(j < 6 && capture_mode_in[j/2]) && f[j/2] == m_act[j];
      md = j < 6 && second_timer_mod_en_in[j] &&
           !(second_timer_compare_signal_in ^ m_inv);
      o[j] = (pas || md) ? passive_level_register_in[j]
                         : !passive_level_register_in[j];
    end
    return o;
  endfunction

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_total++;
    end_of_test;
  end

  initial begin
    {seed, err_total, samples_checked} = {32'd15093, 64'd0};
    {ref_clk_in, rst_n_in, avs_read_in, avs_write_in} = 4'h0;
    {first_timer_shadow_in, second_timer_shadow_in, hall_sample_in} = 3'h0;
    {avs_address_in, avs_writedata_in, hw_set_in, hw_clr_in} = '0;
    {capture_mode_in, hall_pin_in, second_timer_compare_signal_in} = '0;
    {passive_level_register_in, second_timer_mod_en_in} = '0;
    avs_byteenable_in = 4'hF;
    {m_flag, m_irq, m_sh, m_act, m_inv} = '0;
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    bus(0, IDX_STATUS, 16'h0000);
    chk("status_reset", rd, 32'h0000_0000);
    bus(0, IDX_MODIFY, 16'h0000);
    chk("modify_reset", rd, 32'h0000_0000);
    bus(1, 16'h0100, 16'hFFFF);
    bus(0, 16'h0100, 16'h0000);
    chk("unmapped", rd, 32'h0000_0000);
    $display("test reset values done");
    for (int i = 0; i < 40; i++) begin
      wd = 16'($random(seed));
      if (i < 12) wd = ((i / 4 != 1) ? 16'h1 << FLAG_BIT[i % 4] : 16'h0) |
                       ((i / 4 != 0) ? 16'h1 << CLR_BIT[i % 4] : 16'h0);
      bus(1, IDX_MODIFY, wd);
      m_flag = sw_mod(m_flag, wd);
      bus(0, IDX_STATUS, 16'h0000);
      chk("modify_flags", rd, stat_exp(3'h0));
    end
    hw_set_in <= 4'h8;
    bus(1, IDX_MODIFY, 16'h4000);
    #1 chk("sw_over_hw", channel_state_flag_out[3], 1'b0);
    @(posedge ref_clk_in);
    hw_set_in <= 4'h0;
    {m_flag[3], m_irq} = {1'b1, 4'h8};
    $display("test state modify done");
    for (int i = 0; i < 8; i++) begin
      wd = 16'($random(seed));
      bus(1, IDX_STATUS, wd);
      {m_inv, m_sh} = wd[15:8];
      bus(0, IDX_STATUS, 16'h0000);
      chk("shadow_write", rd, stat_exp(3'h0));
      @(posedge ref_clk_in);
      first_timer_shadow_in  <= i[0];
      second_timer_shadow_in <= !i[0];
      @(posedge ref_clk_in);
      {first_timer_shadow_in, second_timer_shadow_in} <= 2'b00;
      if (i[0]) m_act[5:0] = m_sh[5:0];
      else m_act[6] = m_sh[6];
      bus(0, IDX_STATUS, 16'h0000);
      chk("active_select", rd, stat_exp(3'h0));
    end
    $display("test select shadow done");
    bus(1, IDX_IRQ_EN, 16'h0005);
    avs_byteenable_in <= 4'hE;
    bus(1, IDX_IRQ_EN, 16'h000A);
    avs_byteenable_in <= 4'hF;
    bus(0, IDX_IRQ_EN, 16'h0000);
    chk("irq_enable_lanes", rd, 32'h0000_0005);
    for (int i = 0; i < 300; i++) begin
      s = 4'($random(seed) & $random(seed));
      c = 4'($random(seed));
      @(posedge ref_clk_in);
      {hw_set_in, hw_clr_in} <= {s, c};
      capture_mode_in <= 3'($random(seed));
      passive_level_register_in <= 7'($random(seed));
      second_timer_mod_en_in <= 6'($random(seed));
      second_timer_compare_signal_in <= 1'($random(seed));
      @(posedge ref_clk_in);
      {hw_set_in, hw_clr_in} <= 8'h00;
      m_prev = m_flag;
      for (int k = 0; k < N_CH; k++)
        m_flag[k] = s[k] | (m_flag[k] &
                    !(c[k] & !(k < 3 && capture_mode_in[k])));
      m_irq = m_irq | (s & ~m_prev);
      #1 chk("hw_flags", channel_state_flag_out, m_flag);
      chk("out_levels", pins, out_exp(m_prev));
    end
    @(posedge ref_clk_in);
    #1 chk("irq_level", irq_out, |(m_irq & 4'h5));
    bus(0, IDX_IRQ_STAT, 16'h0000);
    chk("irq_status", rd, m_irq);
    bus(1, IDX_IRQ_CLR, 16'h000F);
    bus(0, IDX_IRQ_STAT, 16'h0000);
    chk("irq_cleared", rd, 32'h0000_0000);
    chk("irq_low", irq_out, 1'b0);
    $display("test hardware events done");
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk_in);
      hall_pin_in <= 3'($random(seed));
      repeat (6) @(posedge ref_clk_in);
      hall_sample_in <= 1'b1;
      @(posedge ref_clk_in);
      hall_sample_in <= 1'b0;
      bus(0, IDX_STATUS, 16'h0000);
      chk("hall_bits", rd, stat_exp(hall_pin_in));
    end
    $display("test hall sample done");
    end_of_test;
  end
endmodule // test_compare_channel_state_control
